// File: design/pwch_handler.v
// protected bit-write / word-write command handler and status byte builder
`timescale 1ns/10ps
`include "pwch_defs.vh"
module pwch_handler
(
  input  wire        i_sys_clk,
  input  wire        i_reset_n,
  input  wire        i_cmd_start,
  input  wire [7:0]  i_cmd_code,
  input  wire [7:0]  i_cmd_tns,
  input  wire        i_rx_valid,
  input  wire [7:0]  i_rx_byte,
  input  wire        i_rx_last,
  output wire        o_rx_ready,
  input  wire [7:0]  i_allow_lo,
  input  wire [7:0]  i_allow_hi,
  input  wire [7:0]  i_ext_rd_addr,
  output wire [7:0]  o_ext_rd_data,
  output reg         o_reply_valid,
  output reg  [7:0]  o_reply_cmd,
  output reg  [7:0]  o_reply_sts,
  output reg  [7:0]  o_reply_tns,
  output reg  [7:0]  o_reply_len,
  input  wire        i_rx_from_serial,
  input  wire [3:0]  i_context,
  input  wire [15:0] i_mode_word,
  input  wire [15:0] i_hwy_cnt_addr,
  input  wire [15:0] i_ser_cnt_addr,
  input  wire [4:0]  i_revision,
  input  wire [2:0]  i_series,
  input  wire [31:0] i_unused_addr,
  input  wire [31:0] i_mem_words,
  input  wire [7:0]  i_thumbwheel,
  input  wire [4:0]  i_stat_index,
  output reg  [7:0]  o_stat_byte
);

  ////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE  = 3'd0;
  localparam ST_ALO   = 3'd1;
  localparam ST_AHI   = 3'd2;
  localparam ST_SET   = 3'd3;
  localparam ST_CLR   = 3'd4;
  localparam ST_READ  = 3'd5;
  localparam ST_MOD   = 3'd6;
  localparam ST_DATA  = 3'd7;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg         is_bit;
  reg  [15:0] addr;
  reg  [7:0]  set_mask;
  reg  [7:0]  clr_mask;
  reg  [7:0]  count;
  reg         denied;
  reg         too_long;
  reg         last_seen;
  reg         wr_en;
  reg  [7:0]  wr_data;
  reg  [7:0]  rd_addr;
  wire [7:0]  rd_data;
  wire        take;
  wire        allowed;
  wire        at_limit;
  wire        bw_done;
  wire        ww_done;
  wire [7:0]  mod_byte;
  reg  [7:0]  next_sts;
  reg         accept;
  genvar      gi;

  // byte handshake: ready only in states that take a data byte
  always @*
  begin
    accept = 1'b0;
    case (state)
      ST_ALO, ST_AHI, ST_SET, ST_CLR, ST_DATA : accept = 1'b1;
      default : accept = 1'b0;
    endcase
  end

  assign o_rx_ready = accept;
  assign take       = i_rx_valid & o_rx_ready;
  assign at_limit   = (count == `PWCH_MAX_WRITE_BYTES);
  assign bw_done    = (state == ST_MOD) & last_seen;
  assign ww_done    = (state == ST_DATA) & take & i_rx_last;
  // permitted window of the data table set by controller program
  assign allowed = (addr[15:8] == 8'h00) && (addr[7:0] >= i_allow_lo) &&
                   (addr[7:0] <= i_allow_hi);

  ////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE : if (i_cmd_start) next_state = ST_ALO;
      ST_ALO  : if (take) next_state = ST_AHI;
      ST_AHI  : if (take) next_state = is_bit ? ST_SET : ST_DATA;
      ST_SET  : if (take) next_state = ST_CLR;
      ST_CLR  : if (take) next_state = ST_READ;
      ST_READ : next_state = ST_MOD;
      ST_MOD  : next_state = last_seen ? ST_IDLE : ST_ALO;
      ST_DATA : if (take && i_rx_last) next_state = ST_IDLE;
      default : next_state = ST_IDLE;
    endcase
  end

  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state         <= ST_IDLE;
      is_bit        <= 1'b0;
      addr          <= 16'h0000;
      set_mask      <= 8'h00;
      clr_mask      <= 8'h00;
      count         <= 8'h00;
      denied        <= 1'b0;
      too_long      <= 1'b0;
      last_seen     <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      case (state)
        ST_IDLE :
          if (i_cmd_start)
          begin
            is_bit      <= (i_cmd_code == `PWCH_CMD_BIT_WRITE);
            denied      <= 1'b0;
            too_long    <= 1'b0;
            count       <= 8'h00;
          end
        ST_ALO :
          if (take)
            addr[7:0] <= i_rx_byte;
        ST_AHI :
          if (take)
            addr[15:8] <= i_rx_byte;
        ST_SET :
          if (take)
            set_mask <= i_rx_byte;
        ST_CLR :
          if (take)
          begin
            clr_mask  <= i_rx_byte;
            last_seen <= i_rx_last;
          end
        ST_READ : ;
        ST_MOD :
          if (!allowed)
            denied <= 1'b1;
        ST_DATA :
          if (take)
          begin
            if (at_limit)
              too_long <= 1'b1;
            else if (!allowed)
              denied <= 1'b1;
            count <= count + 8'h01;
            addr  <= addr + 16'h0001;
          end
        default : ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-bit modify: set mask forces one, clear mask forces zero and wins where both masks are set
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_mod_bit
      assign mod_byte[gi] = (rd_data[gi] | set_mask[gi]) & ~clr_mask[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // memory port: one write per in-window modify step or per in-window data byte except the one taken when count is at the length limit
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_en   <= 1'b0;
      wr_data <= 8'h00;
      rd_addr <= 8'h00;
    end
    else
    begin
      wr_en <= 1'b0;
      if ((state == ST_CLR) && take)
        rd_addr <= addr[7:0];
      if ((state == ST_MOD) && allowed)
      begin
        wr_en   <= 1'b1;
        wr_data <= mod_byte;
      end
      if ((state == ST_DATA) && take && !at_limit && allowed)
      begin
        wr_en   <= 1'b1;
        wr_data <= i_rx_byte;
        rd_addr <= addr[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply status: length error first on word write, else denied if any byte fell outside the window
  always @*
  begin
    next_sts = `PWCH_STS_OK;
    if (bw_done)
    begin
      if (denied || !allowed)
        next_sts = `PWCH_STS_DENIED;
    end
    else if (too_long || at_limit)
      next_sts = `PWCH_STS_BAD_LEN;
    else if (denied || !allowed)
      next_sts = `PWCH_STS_DENIED;
  end

  // reply header: valid pulses one cycle, the other fields hold
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_reply_valid <= 1'b0;
      o_reply_cmd   <= 8'h00;
      o_reply_sts   <= 8'h00;
      o_reply_tns   <= 8'h00;
      o_reply_len   <= 8'h00;
    end
    else
    begin
      o_reply_valid <= bw_done | ww_done;
      if ((state == ST_IDLE) && i_cmd_start)
      begin
        o_reply_cmd <= i_cmd_code | `PWCH_REPLY_FLAG;
        o_reply_tns <= i_cmd_tns;
      end
      if (bw_done || ww_done)
      begin
        o_reply_sts <= next_sts;
        o_reply_len <= {5'h00, `PWCH_HEADER_LEN};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared memory: write port from handler, read for modify or external
  pwch_data_mem u_mem
  (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_wr_en   (wr_en),
    .i_wr_addr (rd_addr),
    .i_wr_data (wr_data),
    .i_rd_addr ((state == ST_IDLE) ? i_ext_rd_addr : rd_addr),
    .o_rd_data (rd_data)
  );
  assign o_ext_rd_data = rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // status reply bytes, index counts from 1
  wire [15:0] cnt_addr;
  reg  [7:0]  next_stat_byte;
  assign cnt_addr = i_rx_from_serial ? i_ser_cnt_addr : i_hwy_cnt_addr;

  always @*
  begin
    next_stat_byte = 8'h00;
    case (i_stat_index)
      5'd2  : next_stat_byte = {`PWCH_PROC_TYPE,
                                i_rx_from_serial ? `PWCH_PORT_SERIAL
                                                 : `PWCH_PORT_HIGHWAY};
      5'd3  : next_stat_byte = {i_context, 4'h0};
      5'd4  : next_stat_byte = i_thumbwheel;
      5'd5  : next_stat_byte = i_mode_word[7:0];
      5'd6  : next_stat_byte = i_mode_word[15:8];
      5'd7  : next_stat_byte = cnt_addr[7:0];
      5'd8  : next_stat_byte = cnt_addr[15:8];
      5'd9  : next_stat_byte = {i_series, i_revision};
      5'd10 : next_stat_byte = 8'h00;
      5'd11 : next_stat_byte = i_unused_addr[7:0];
      5'd12 : next_stat_byte = i_unused_addr[15:8];
      5'd13 : next_stat_byte = i_unused_addr[23:16];
      5'd14 : next_stat_byte = i_unused_addr[31:24];
      5'd15 : next_stat_byte = i_mem_words[7:0];
      5'd16 : next_stat_byte = i_mem_words[15:8];
      5'd17 : next_stat_byte = i_mem_words[23:16];
      5'd18 : next_stat_byte = i_mem_words[31:24];
      default : next_stat_byte = 8'h00;
    endcase
  end

  // status byte leaves one cycle after its index
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_stat_byte <= 8'h00;
    else
      o_stat_byte <= next_stat_byte;
  end

endmodule // pwch_handler

// File: include/pwch_defs.vh
// constants for the protected write command handler
// Operation
// - status byte 2 holds answering port code low nibble, processor type high nibble
// - status byte 3 carries current context number in bits 4 to 7
// - status bytes 5 and 6 return the mode control word
// - status bytes 7 and 8 give counter block address of the receiving port
// - status byte 9 holds revision in bits 0-4, series in bits 5-7
// - status bytes 11 to 14 hold first unused system memory word address
// - status bytes 15 to 18 hold total system memory word count
// - bit-write only touches data-table areas the access rules permit
// - bit-write data is 4-byte entries: address, set mask, clear mask
// - set mask ones force addressed bits to 1, zeros leave bits alone (here a clear mask one on the same bit wins and gives 0)
// - clear mask ones force addressed bits to 0, zeros leave bits alone
// - each bit-write entry is read, masked, then written back
// - word-write stores words only where the access rules permit
`ifndef PWCH_DEFS_VH
`define PWCH_DEFS_VH
`define PWCH_CMD_BIT_WRITE   8'h02
`define PWCH_CMD_WORD_WRITE  8'h00
`define PWCH_REPLY_FLAG      8'h40
`define PWCH_MAX_WRITE_BYTES 8'hf3
`define PWCH_STS_OK          8'h00
`define PWCH_STS_DENIED      8'h10
`define PWCH_STS_BAD_LEN     8'h20
`define PWCH_PORT_HIGHWAY    4'h1  // arbitrary code
`define PWCH_PORT_SERIAL     4'h2  // arbitrary code
`define PWCH_PROC_TYPE       4'h3  // arbitrary code
`define PWCH_STATUS_LEN      5'h12
`define PWCH_HEADER_LEN      3'h5
`endif

// File: design/pwch_data_mem.v
// small byte-wide data-table memory with registered read data
`timescale 1ns/10ps
module pwch_data_mem
(
  input  wire        i_sys_clk,
  input  wire        i_reset_n,
  input  wire        i_wr_en,
  input  wire [7:0]  i_wr_addr,
  input  wire [7:0]  i_wr_data,
  input  wire [7:0]  i_rd_addr,
  output reg  [7:0]  o_rd_data
);

  reg [7:0] mem [0:255];

  always @(posedge i_sys_clk)
  begin
    if (i_wr_en)
      mem[i_wr_addr] <= i_wr_data;
  end

  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rd_data <= 8'h00;
    else
      o_rd_data <= mem[i_rd_addr];
  end

endmodule // pwch_data_mem

// File: sim/pwch_props.sv
// assertions on the command handler ports
`timescale 1ns/10ps
module pwch_props
(
  input wire       i_sys_clk,
  input wire       i_reset_n,
  input wire       i_cmd_start,
  input wire [7:0] i_cmd_code,
  input wire       i_rx_valid,
  input wire       i_rx_last,
  input wire       o_rx_ready,
  input wire       o_reply_valid,
  input wire [7:0] o_reply_cmd,
  input wire [7:0] o_reply_len,
  input wire       i_rx_from_serial,
  input wire [3:0] i_context,
  input wire [4:0] i_revision,
  input wire [2:0] i_series,
  input wire [4:0] i_stat_index,
  input wire [7:0] o_stat_byte
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  reg [7:0] code;
  always @(posedge i_sys_clk or negedge i_reset_n)
    if (!i_reset_n) code <= 8'h00;
    else if (i_cmd_start) code <= i_cmd_code;
  sequence s_end;
    i_rx_valid && o_rx_ready && i_rx_last;
  endsequence
  sequence s_bw_end;
    code == 8'h02 ##0 s_end;
  endsequence
  a_bw_reply_time: assert property (s_bw_end |=> !o_reply_valid [*2] ##1 o_reply_valid)
    else $error("bit write reply timing");
  a_rmw_no_take: assert property (s_bw_end |=> !o_rx_ready [*2])
    else $error("byte taken during read modify write");
  a_ww_reply_time: assert property (code != 8'h02 ##0 s_end |=> o_reply_valid)
    else $error("word write reply timing");
  a_reply_one_cycle: assert property (o_reply_valid |=> !o_reply_valid)
    else $error("reply pulse too long");
  a_reply_header: assert property (o_reply_valid |-> o_reply_len == 8'h05 && o_reply_cmd == (code | 8'h40))
    else $error("reply header wrong");
  a_stat_port_type: assert property (i_stat_index == 5'h02 |=>
    o_stat_byte == {4'h3, $past(i_rx_from_serial) ? 4'h2 : 4'h1})
    else $error("status byte 2 wrong");
  a_stat_context: assert property (i_stat_index == 5'h03 |=> o_stat_byte == {$past(i_context), 4'h0})
    else $error("status byte 3 wrong");
  a_stat_revision: assert property (i_stat_index == 5'h09 |=>
    o_stat_byte == {$past(i_series), $past(i_revision)})
    else $error("status byte 9 wrong");
  a_stat_unused: assert property (i_stat_index == 5'h0a |=> o_stat_byte == 8'h00)
    else $error("status byte 10 not zero");
endmodule // pwch_props
bind pwch_handler pwch_props u_props
(
  .i_sys_clk        (i_sys_clk),
  .i_reset_n        (i_reset_n),
  .i_cmd_start      (i_cmd_start),
  .i_cmd_code       (i_cmd_code),
  .i_rx_valid       (i_rx_valid),
  .i_rx_last        (i_rx_last),
  .o_rx_ready       (o_rx_ready),
  .o_reply_valid    (o_reply_valid),
  .o_reply_cmd      (o_reply_cmd),
  .o_reply_len      (o_reply_len),
  .i_rx_from_serial (i_rx_from_serial),
  .i_context        (i_context),
  .i_revision       (i_revision),
  .i_series         (i_series),
  .i_stat_index     (i_stat_index),
  .o_stat_byte      (o_stat_byte)
);

// File: sim/pwch_sender.sv
// remote station model driving the command data bytes
`timescale 1ns/10ps
module pwch_sender
(
  input  wire       i_sys_clk,
  input  wire       i_rx_ready,
  output reg        o_valid,
  output reg  [7:0] o_byte,
  output reg        o_last
);
  initial
  begin
    o_valid = 1'b0;
    o_byte = 8'h00;
    o_last = 1'b0;
  end
  task send(input [7:0] d, input l);
    begin
      @(negedge i_sys_clk);
      o_valid = 1'b1;
      o_byte = d;
      o_last = l;
      @(posedge i_sys_clk);
      while (i_rx_ready !== 1'b1) @(posedge i_sys_clk);
    end
  endtask
  // released bus shows the inverse of the last byte
  task release_bus;
    begin
      @(negedge i_sys_clk);
      o_valid = 1'b0;
      o_byte = ~o_byte;
      o_last = 1'b0;
    end
  endtask
  task entry(input [15:0] a, input [7:0] s, input [7:0] c, input l);
    begin
      send(a[7:0], 1'b0);
      send(a[15:8], 1'b0);
      send(s, 1'b0);
      send(c, l);
    end
  endtask
endmodule // pwch_sender

// File: sim/tb.sv
// self-checking bench for the command handler
`timescale 1ns/10ps
module tb;
  reg         clk = 1'b0, rst_n = 1'b0, start = 1'b0, ser = 1'b0;
  reg  [7:0]  code = 8'h00, tns = 8'h00, lo = 8'h00, hi = 8'hff, ra = 8'h00, thw = 8'h2c;
  reg  [3:0]  ctx = 4'h9;
  reg  [15:0] mw = 16'hc3a1, hca = 16'h1234, sca = 16'h5678;
  reg  [4:0]  rev = 5'h13, idx = 5'h00;
  reg  [2:0]  sr = 3'h5;
  reg  [31:0] ua = 32'h0a0b0c0d, mwc = 32'h11223344;
  wire        v, last, rdy, rv;
  wire [7:0]  b, rd, rc, rs, rt, rl, sb;
  integer     err_count = 0, n_checks = 0, i, j, n;
  pwch_handler DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_cmd_start(start), .i_cmd_code(code),
    .i_cmd_tns(tns), .i_rx_valid(v), .i_rx_byte(b), .i_rx_last(last), .o_rx_ready(rdy),
    .i_allow_lo(lo), .i_allow_hi(hi), .i_ext_rd_addr(ra), .o_ext_rd_data(rd),
    .o_reply_valid(rv), .o_reply_cmd(rc), .o_reply_sts(rs), .o_reply_tns(rt), .o_reply_len(rl),
    .i_rx_from_serial(ser), .i_context(ctx), .i_mode_word(mw), .i_hwy_cnt_addr(hca),
    .i_ser_cnt_addr(sca), .i_revision(rev), .i_series(sr), .i_unused_addr(ua),
    .i_mem_words(mwc), .i_thumbwheel(thw), .i_stat_index(idx), .o_stat_byte(sb));
  pwch_sender S (.i_sys_clk(clk), .i_rx_ready(rdy), .o_valid(v), .o_byte(b), .o_last(last));
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task check(input [8*6-1:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("Error %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task go(input [7:0] c);
    begin
      @(negedge clk);
      start = 1'b1;
      code = c;
      tns = tns + 8'h01;
      @(negedge clk);
      start = 1'b0;
    end
  endtask
  task reply(input [7:0] s);
    begin
      S.release_bus;
      check("rdy", {7'h00, rdy}, 8'h00);
      j = 0;
      while (rv !== 1'b1 && j < 8)
      begin
        @(posedge clk);
        #1 j = j + 1;
      end
      check("valid", {7'h00, rv}, 8'h01);
      check("cmd", rc, code | 8'h40);
      check("sts", rs, s);
      check("tns", rt, tns);
      check("len", rl, 8'h05);
    end
  endtask
  task rdm(input [7:0] a, input [7:0] e);
    begin
      @(negedge clk);
      ra = a;
      @(negedge clk);
      check("mem", rd, e);
    end
  endtask
  function [7:0] es(input integer k);
    reg [31:0] lw;
    reg [63:0] hw;
    begin
      lw = {ser ? sca : hca, mw};
      hw = {mwc, ua};
      es = 8'h00;
      if (k == 2) es = {4'h3, ser ? 4'h2 : 4'h1};
      if (k == 3) es = {ctx, 4'h0};
      if (k == 4) es = thw;
      if (k >= 5 && k <= 8) es = lw[8*(k-5)+:8];
      if (k == 9) es = {sr, rev};
      if (k >= 11) es = hw[8*(k-11)+:8];
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000 err_count = err_count + 1;
    finish_test;
  end
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    for (n = 244; n > 242; n = n - 1)
    begin
      go(8'h00);
      S.send(8'h00, 1'b0);
      S.send(8'h00, 1'b0);
      for (i = 0; i < n; i = i + 1)
        S.send(i[7:0] ^ {8{n[0]}}, i == n - 1);
      reply(n == 244 ? 8'h20 : 8'h00);
      rdm(8'hf2, 8'hf2 ^ {8{n[0]}});
    end
    go(8'h02);
    S.entry(16'h0010, 8'h10, 8'h0f, 1'b0);
    S.entry(16'h0011, 8'h01, 8'h80, 1'b0);
    S.release_bus;
    S.entry(16'h0012, 8'h00, 8'h00, 1'b1);
    reply(8'h00);
    rdm(8'h10, 8'hf0);
    rdm(8'h11, 8'h6f);
    rdm(8'h12, 8'hed);
    lo = 8'h20;
    hi = 8'h2f;
    go(8'h02);
    S.entry(16'h0010, 8'hff, 8'h00, 1'b1);
    reply(8'h10);
    rdm(8'h10, 8'hf0);
    go(8'h00);
    S.send(8'h30, 1'b0);
    S.send(8'h00, 1'b0);
    S.send(8'h55, 1'b1);
    reply(8'h10);
    rdm(8'h30, 8'hcf);
    for (n = 0; n < 2; n = n + 1)
      for (i = 2; i < 19; i = i + 1)
      begin
        @(negedge clk);
        ser = n[0];
        idx = i[4:0];
        @(negedge clk);
        check("stat", sb, es(i));
      end
    finish_test;
  end
endmodule // tb
